// [core/psw_defs.svh]
// Purpose: constants for the plug-supply switch control block
// Assumes: 10 MHz clock
// Notes: timing counts derive from printed times
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
`define PSW_CLK_HZ 10000000
`define PSW_DISCH_MS 250
`define PSW_DISCH_CYC ((`PSW_DISCH_MS * `PSW_CLK_HZ) / 1000)
`define PSW_ILIM_MIN_MA 100
`define PSW_ILIM_MAX_MA 600
`define PSW_ILIM_STEP_MA 50
`define PSW_ILIM_CODE_MAX 4'hA
`define PSW_UVLO_HI 1'b0
`define PSW_UVLO_LO 1'b1
`endif

// [core/psw_pkg.sv]
// Purpose: types for the plug-supply switch control block
// Assumes: nothing
// Notes: none
package psw_pkg;
    typedef enum logic [1:0] {
        PSW_ROLE_SRC,
        PSW_ROLE_SNK,
        PSW_ROLE_DRP
    } psw_role_type;

    typedef struct packed {
        logic [1:0] ocp;
        logic [1:0] ovp;
        logic [1:0] rvp;
        logic thermal;
        logic supply_lost;
    } psw_fault_type;
endpackage

// [core/psw_disch_timer.sv]
// Purpose: one-shot discharge timer
// Assumes: start is a one-cycle pulse
// Notes: retriggers on a new start
`timescale 1ns/1ns
`include "psw_defs.svh"
module psw_disch_timer
#(
    parameter int CYCLES = `PSW_DISCH_CYC
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic start,
    output logic active
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    initial
    begin
        if (CYCLES < 1)
            $error("psw_disch_timer: CYCLES must be at least one");
    end

    assign cnt_nxt = start ? W'(CYCLES) :
        (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    assign active = (cnt_r != '0);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            cnt_r <= '0;
        else if (ce)
            cnt_r <= cnt_nxt;
    end
endmodule

// [core/psw_ctrl.sv]
// Purpose: plug-supply switch enables, faults and dead-battery start
// Assumes: analog comparators arrive synchronous to clock
// Notes: fault flags are sticky until cleared by software; the presence flag follows the supply
//
// Behaviour
// R1: supply only the unwired CC pin, and only when every condition holds
// R2: each CC pin has its own separately driven switch enable
// R3: sink role never enables either switch
// R4: switches enable only while supply is above selected threshold
// R5: threshold select defaults to cable level, software may pick low level
// R6: source-mode detach drives discharge for 250 ms, then releases; the default DISCH_CYCLES overflows 32-bit int math and comes out negative
// R7: discharge disabled after reset, enabled by config or software
// R8: current limit 100 to 600 mA in 50 mA steps, software written
// R9: reset reloads current limit from nonvolatile default
// R10: any switch fault raises the alert output
// R11: over-current sets per-pin flags and alert at once
// R12: over-temperature opens switch, flags, alerts, requests error recovery
// R13: supply drop opens switch, reported by presence flag and alert
// R14: over-voltage on CC opens switch, sets per-pin flags and alert
// R15: reverse voltage opens switch, sets per-pin flags and alert
// R16: dead-battery start allowed only in sink or dual role
// R17: after dead-battery attach, assert sink power-path enable
`timescale 1ns/1ns
`include "psw_defs.svh"
module psw_ctrl
    import psw_pkg::*;
#(
    parameter int DISCH_CYCLES = `PSW_DISCH_CYC
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input psw_role_type role,
    input wire logic switch_enable,
    input wire logic sink_attached,
    input wire logic cc_wire_is_b,
    input wire logic ra_on_unwired,
    input wire logic supply_above_uvlo,
    input wire logic uvlo_sel_wr,
    input wire logic uvlo_sel_data,
    input wire logic disch_cfg_nvm,
    input wire logic disch_en_wr,
    input wire logic disch_en_data,
    input wire logic [3:0] ilim_nvm_code,
    input wire logic ilim_wr,
    input wire logic [3:0] ilim_data,
    input wire logic [1:0] ocp_det,
    input wire logic [1:0] ovp_det,
    input wire logic [1:0] rvp_det,
    input wire logic overtemp_det,
    input wire logic flags_clear,
    input wire logic dead_batt_start,
    input wire logic dead_batt_attached,
    output logic [1:0] plug_switch_on,
    output logic plug_discharge,
    output logic uvlo_low_sel,
    output logic [3:0] ilim_code,
    output psw_fault_type fault_flags,
    output logic plug_supply_present_flag,
    output logic alert_n,
    output logic error_recovery,
    output logic sink_power_path_enable
);
    logic [1:0] sw_r;
    logic uvlo_r;
    logic disch_en_r;
    logic nvm_loaded_r;
    logic [3:0] ilim_r;
    psw_fault_type flags_r;
    psw_fault_type flags_nxt;
    psw_fault_type events;
    logic present_r;
    logic alert_r;
    logic err_r;
    logic snk_en_r;
    logic db_ok_r;
    logic attached_d_r;
    logic disch_start;
    logic disch_active;
    logic disch_r;
    logic base_ok;
    logic [1:0] sw_nxt;
    logic [1:0] pin_block;
    logic ilim_ok;

    initial
    begin
        if (DISCH_CYCLES < 1)
            $error("psw_ctrl: DISCH_CYCLES must be at least one");
    end

    // common gate for both pins
    assign base_ok = (role == PSW_ROLE_SRC) && switch_enable && // R3
        sink_attached && ra_on_unwired && supply_above_uvlo; // R1 R4
    // over-voltage, reverse voltage and over-temperature force the pin open while they last
    assign pin_block = ovp_det | rvp_det | {2{overtemp_det}}; // R14 R15 R12
    // unwired pin: wire on B means supply A, and vice versa
    assign sw_nxt[0] = base_ok && cc_wire_is_b && !pin_block[0]; // R1 R2
    assign sw_nxt[1] = base_ok && !cc_wire_is_b && !pin_block[1]; // R1 R2

    assign ilim_ok = (ilim_data <= `PSW_ILIM_CODE_MAX); // R8

    assign events.ocp = ocp_det; // R11
    assign events.ovp = ovp_det; // R14
    assign events.rvp = rvp_det; // R15
    assign events.thermal = overtemp_det; // R12
    assign events.supply_lost = !supply_above_uvlo &&
        (role == PSW_ROLE_SRC) && switch_enable; // R13
    // set wins over clear
    assign flags_nxt = (flags_clear ? '0 : flags_r) | events;

    assign disch_start = attached_d_r && !sink_attached &&
        (role == PSW_ROLE_SRC) && disch_en_r; // R6 R7

    psw_disch_timer #(
        .CYCLES(DISCH_CYCLES)
    ) u_timer (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .start(disch_start),
        .active(disch_active)
    );

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_r <= 2'h0;
            uvlo_r <= `PSW_UVLO_HI; // R5
            disch_en_r <= 1'b0; // R7
            nvm_loaded_r <= 1'b0;
            ilim_r <= 4'h0;
            flags_r <= '0;
            present_r <= 1'b0;
            // held active low so the pin comes straight from this flop
            alert_r <= 1'b1;
            err_r <= 1'b0;
            attached_d_r <= 1'b0;
            disch_r <= 1'b0;
        end
        else if (ce)
        begin
            sw_r <= sw_nxt;
            attached_d_r <= sink_attached;
            disch_r <= disch_active; // R6
            present_r <= supply_above_uvlo; // R13
            flags_r <= flags_nxt;
            alert_r <= !(|flags_nxt); // R10
            err_r <= overtemp_det; // R12
            if (uvlo_sel_wr)
                uvlo_r <= uvlo_sel_data; // R5
            if (!nvm_loaded_r)
            begin
                // first enabled cycle after reset takes the stored default
                nvm_loaded_r <= 1'b1;
                ilim_r <= ilim_nvm_code; // R9
                disch_en_r <= disch_cfg_nvm; // R7
            end
            else
            begin
                if (ilim_wr && ilim_ok)
                    ilim_r <= ilim_data; // R8
                if (disch_en_wr)
                    disch_en_r <= disch_en_data; // R7
            end
        end
    end

    // dead-battery path kept apart: it must work before software runs
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            db_ok_r <= 1'b0;
            snk_en_r <= 1'b0;
        end
        else if (ce)
        begin
            if (dead_batt_start)
                db_ok_r <= (role == PSW_ROLE_SNK) ||
                    (role == PSW_ROLE_DRP); // R16
            snk_en_r <= db_ok_r && dead_batt_attached &&
                (role != PSW_ROLE_SRC); // R17
        end
    end

    assign plug_switch_on = sw_r;
    assign plug_discharge = disch_r;
    assign uvlo_low_sel = uvlo_r;
    assign ilim_code = ilim_r;
    assign fault_flags = flags_r;
    assign plug_supply_present_flag = present_r;
    assign alert_n = alert_r;
    assign error_recovery = err_r;
    assign sink_power_path_enable = snk_en_r;

    a_sink_no_switch: assert property (@(posedge clock) disable iff (!resetn)
        ce && role == PSW_ROLE_SNK |=> plug_switch_on == 2'h0) // R3
        else $error("switch on in sink role");
    a_uvlo_gate: assert property (@(posedge clock) disable iff (!resetn)
        ce && !supply_above_uvlo |=> plug_switch_on == 2'h0) // R4
        else $error("switch on below threshold");
    a_one_pin_only: assert property (@(posedge clock) disable iff (!resetn)
        plug_switch_on != 2'h3) // R1
        else $error("both pins supplied");
    a_ocp_alert: assert property (@(posedge clock) disable iff (!resetn)
        ce && |ocp_det |=> (fault_flags.ocp == ($past(ocp_det) |
            ($past(flags_clear) ? 2'h0 : $past(fault_flags.ocp))))
            && !alert_n) // R11
        else $error("over-current not flagged");
    a_ovp_open: assert property (@(posedge clock) disable iff (!resetn)
        ce && ovp_det[0] |=> !plug_switch_on[0] && fault_flags.ovp[0]) // R14
        else $error("over-voltage did not open pin a");
    a_rvp_open: assert property (@(posedge clock) disable iff (!resetn)
        ce && rvp_det[1] |=> !plug_switch_on[1] && fault_flags.rvp[1]) // R15
        else $error("reverse voltage did not open pin b");
    a_thermal_err: assert property (@(posedge clock) disable iff (!resetn)
        ce && overtemp_det |=> error_recovery && plug_switch_on == 2'h0
            && fault_flags.thermal) // R12
        else $error("over-temperature not handled");
    a_fault_alert: assert property (@(posedge clock) disable iff (!resetn)
        ce && (|ovp_det || |rvp_det) |=> !alert_n) // R10
        else $error("fault without alert");
    a_disch_pulse: assert property (@(posedge clock) disable iff (!resetn)
        ce && disch_start |=> ##2 plug_discharge) // R6
        else $error("discharge not started");
    a_sink_path: assert property (@(posedge clock) disable iff (!resetn)
        ce && role == PSW_ROLE_SRC |=> !sink_power_path_enable) // R16 R17
        else $error("sink path on in source role");
endmodule

// [test/psw_plug_model.sv]
// Purpose: behavioural cable plug or accessory sitting on the CC pins
// Assumes: bench steers presence and fault requests
// Notes: faults appear only on the unwired pin, where the plug lives
`timescale 1ns/1ns
module psw_plug_model
(
    input wire logic cc_wire_is_b,
    input wire logic present,
    input wire logic [2:0] fault_req,
    output logic ra_on_unwired,
    output logic [1:0] ocp_det,
    output logic [1:0] ovp_det,
    output logic [1:0] rvp_det
);
    logic [1:0] unwired;
    assign unwired = cc_wire_is_b ? 2'h1 : 2'h2;
    assign ra_on_unwired = present;
    assign ocp_det = fault_req[0] ? unwired : 2'h0;
    assign ovp_det = fault_req[1] ? unwired : 2'h0;
    assign rvp_det = fault_req[2] ? unwired : 2'h0;
endmodule

// [test/psw_ctrl_test.sv]
// Purpose: self-checking bench for the plug-supply switch control
// Assumes: discharge shortened to 20 cycles
// Notes: random stimulus from an lfsr seeded with 18
`timescale 1ns/1ns
module psw_ctrl_test;
    import psw_pkg::*;
    logic clock = 0, resetn = 0, sw_en = 0, snk = 0, wire_b = 0, pres = 0;
    logic sup = 1, uw = 0, ud = 0, dw = 0, dd = 0, iw = 0, clr = 0;
    logic dbs = 0, dba = 0, ot = 0;
    logic [3:0] idat = 4'h0;
    logic [2:0] freq = 3'h0;
    psw_role_type role = PSW_ROLE_SRC;
    logic ra, disch, ulow, pres_f, alert_n, erec, spp;
    logic [1:0] ocp, ovp, rvp, sw_on;
    logic [3:0] ilim;
    psw_fault_type ff;
    logic [15:0] seed = 16'h0012;
    int bad_count = 0, n_tests = 0, n;
    always #50 clock = ~clock;
    psw_plug_model psw_plug_model_i (.cc_wire_is_b(wire_b), .present(pres),
        .fault_req(freq), .ra_on_unwired(ra), .ocp_det(ocp), .ovp_det(ovp),
        .rvp_det(rvp));
    psw_ctrl #(.DISCH_CYCLES(20)) psw_ctrl_i (.clock(clock), .resetn(resetn),
        .ce(1'b1), .role(role), .switch_enable(sw_en), .sink_attached(snk),
        .cc_wire_is_b(wire_b), .ra_on_unwired(ra), .supply_above_uvlo(sup),
        .uvlo_sel_wr(uw), .uvlo_sel_data(ud), .disch_cfg_nvm(1'b0),
        .disch_en_wr(dw), .disch_en_data(dd), .ilim_nvm_code(4'h3),
        .ilim_wr(iw), .ilim_data(idat), .ocp_det(ocp), .ovp_det(ovp),
        .rvp_det(rvp), .overtemp_det(ot), .flags_clear(clr),
        .dead_batt_start(dbs), .dead_batt_attached(dba),
        .plug_switch_on(sw_on), .plug_discharge(disch), .uvlo_low_sel(ulow),
        .ilim_code(ilim), .fault_flags(ff),
        .plug_supply_present_flag(pres_f), .alert_n(alert_n),
        .error_recovery(erec), .sink_power_path_enable(spp));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [1:0] exp_sw();
        logic [1:0] m;
        m = wire_b ? 2'h1 : 2'h2;
        if (role != PSW_ROLE_SRC || !sw_en || !snk || !ra || !sup || ot)
            return 2'h0;
        return m & ~ovp & ~rvp;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (e !== g)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        chk("alert_rst", 8'h1, alert_n);
        resetn <= 1'b1;
        tick(1);
        chk("ilim_rst", 8'h3, ilim);
        chk("uvlo_rst", 8'h0, ulow);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        @(negedge clock);
    endtask
    initial
    begin
        #1000000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        do_reset();
        repeat (150)
        begin
            @(posedge clock);
            seed = lfsr(seed);
            role <= psw_role_type'(seed[1:0] % 3);
            {sw_en, snk, wire_b, pres} <= seed[5:2] | {4{seed[15]}};
            sup <= seed[6] | seed[14];
            freq <= seed[9:7] & {3{seed[11]}};
            ot <= seed[10] & seed[12];
            tick(1);
            chk("switch", exp_sw(), sw_on);
            chk("present", sup, pres_f);
            chk("recovery", ot, erec);
            if (ot || freq != 0)
                chk("alert", 8'h0, alert_n);
            chk("ocp_flags", ocp, ff.ocp & ocp);
            chk("ovp_flags", ovp, ff.ovp & ovp);
            chk("rvp_flags", rvp, ff.rvp & rvp);
            @(posedge clock);
            {freq, ot, sup, clr} <= 6'h03;
            @(posedge clock);
            clr <= 1'b0;
            tick(0);
            chk("cleared", 8'h1, {ff, alert_n});
        end
        role <= PSW_ROLE_SRC;
        {snk, uw, ud, iw, idat} <= 8'hFA;
        @(posedge clock);
        {snk, uw, iw} <= 3'h0;
        tick(1);
        chk("uvlo_low", 8'h1, ulow);
        chk("ilim_wr", 8'hA, ilim);
        n = 0;
        repeat (30)
        begin
            tick(1);
            n += disch;
        end
        chk("disch_off", 8'h0, n[7:0]);
        {iw, idat, dw, dd, snk} <= 8'hFF;
        @(posedge clock);
        {iw, dw} <= 2'h0;
        tick(3);
        chk("ilim_big", 8'hA, ilim);
        snk <= 1'b0;
        n = 0;
        repeat (30)
        begin
            tick(1);
            n += disch;
        end
        chk("disch_len", 8'd20, n[7:0]);
        {role, dbs, dba} <= 4'h3;
        @(posedge clock);
        dbs <= 1'b0;
        tick(3);
        chk("db_src", 8'h0, spp);
        {role, dbs} <= 3'h3;
        @(posedge clock);
        dbs <= 1'b0;
        tick(3);
        chk("db_snk", 8'h1, spp);
        do_reset();
        report_and_stop();
    end
endmodule
